// ==== fetch_pkg.sv ====
// Purpose: Shared constants and carriers for the fetch and branch prediction unit.
// Assumes: 32-bit instruction addresses, 64-bit double words, 32-byte cache blocks.
// Notes: Widths, counts and reset values shared between modules live here; the fill state type is declared in the unit.
package fetch_pkg;
   localparam int ADDR_W = 32;
   localparam int DW_W = 64;
   localparam int INSN_W = 32;
   localparam int BEATS = 4;
   localparam int BEAT_W = 2;
   localparam int DW_LSB = 3;
   localparam int LINE_LSB = 5;
   localparam int INSN_LSB = 2;
   localparam int BTC_ENTRIES = 64;
   localparam int BTC_IDX_W = 6;
   localparam int BHT_ENTRIES = 512;
   localparam int BHT_IDX_W = 9;
   localparam int GPR_PORTS = 2;
   localparam int CMP_SLOTS = 4;
   localparam int CNT_W = 3;
   localparam logic [1:0] BHT_RESET = 2'h1;
   localparam logic [1:0] BHT_MAX = 2'h3;
   localparam logic [1:0] BHT_MIN = 2'h0;
   localparam logic [BEAT_W-1:0] LAST_BEAT = 2'h3;
   localparam logic [ADDR_W-1:0] ONE_LOOP = 32'h0000_0001;

   typedef enum logic [1:0] {BR_UNCOND, BR_LOOP, BR_COND_BIT, BR_OTHER} br_kind_t;

   typedef struct packed {
      logic valid;
      br_kind_t kind;
      logic [ADDR_W-1:0] pc;
      logic [ADDR_W-1:0] target;
      logic [ADDR_W-1:0] fall_thru;
      logic early_taken;
      logic exit_on_last;
   } br_dec_t;

   typedef struct packed {
      logic valid;
      logic cond_bit;
      logic taken;
      logic [ADDR_W-1:0] fetch_addr;
      logic [ADDR_W-1:0] pc;
      logic [ADDR_W-1:0] target;
   } br_exec_t;

   typedef struct packed {
      logic valid;
      logic finished;
      logic final_exec;
      logic uses_gpr;
      logic taken_branch;
   } cmp_slot_t;
endpackage : fetch_pkg

// ==== branch_target_cache.sv ====
// Purpose: Fully associative target cache keyed by fetch address.
// Assumes: Lookup is combinational; updates come from resolved taken branches.
// Notes: Replacement is a plain round-robin pointer.
`timescale 1ns/10ps
`default_nettype none
module branch_target_cache (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [fetch_pkg::ADDR_W-1:0] look_addr,
   output logic look_hit,
   output logic [fetch_pkg::ADDR_W-1:0] look_target,
   input wire fetch_pkg::br_exec_t upd
);
   import fetch_pkg::*;
   logic [BTC_ENTRIES-1:0] valid_reg;
   logic [ADDR_W-1:0] key_mem [BTC_ENTRIES];
   logic [ADDR_W-1:0] tgt_mem [BTC_ENTRIES];
   logic [BTC_ENTRIES-1:0] look_match;
   logic [BTC_ENTRIES-1:0] upd_match;
   logic [BTC_IDX_W-1:0] look_idx;
   logic [BTC_IDX_W-1:0] upd_idx;
   logic [BTC_IDX_W-1:0] rr_reg;
   logic [BTC_IDX_W-1:0] wr_idx;
   wire upd_hit = |upd_match;
   wire do_write = upd.valid && upd.taken;

   genvar g;
   for (g = 0; g < BTC_ENTRIES; g++) begin : g_cmp
      assign look_match[g] = valid_reg[g] && key_mem[g] == look_addr;
      assign upd_match[g] = valid_reg[g] && key_mem[g] == upd.fetch_addr;
   end

   always_comb begin
      look_idx = '0;
      upd_idx = '0;
      for (int i = BTC_ENTRIES - 1; i >= 0; i--) begin
         if (look_match[i]) look_idx = BTC_IDX_W'(i);
         if (upd_match[i]) upd_idx = BTC_IDX_W'(i);
      end
   end

   assign look_hit = |look_match;
   assign look_target = tgt_mem[look_idx];
   assign wr_idx = upd_hit ? upd_idx : rr_reg;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         valid_reg <= '0;
         rr_reg <= '0;
      end else if (do_write) begin
         valid_reg[wr_idx] <= 1'b1;
         if (!upd_hit) rr_reg <= rr_reg + 1'b1;
      end
   end

   // Key and target storage need no reset; the valid bits guard them.
   always_ff @(posedge clk) begin
      if (do_write) begin
         key_mem[wr_idx] <= upd.fetch_addr;
         tgt_mem[wr_idx] <= upd.target;
      end
   end

   property p_btc_replace;
      @(posedge clk) disable iff (!rst_n)
      (do_write && !upd_hit) |=> rr_reg == $past(rr_reg) + 1'b1;
   endproperty
   a_btc_replace: assert property (p_btc_replace) else $error("Replacement pointer failed to advance.");
endmodule : branch_target_cache
`default_nettype wire

// ==== branch_history_table.sv ====
// Purpose: Direct-mapped two-bit history table for condition-bit branches.
// Assumes: Read in decode, written when such a branch executes.
// Notes: Entries start weakly not-taken after reset.
`timescale 1ns/10ps
`default_nettype none
module branch_history_table (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [fetch_pkg::ADDR_W-1:0] rd_pc,
   output logic rd_taken,
   input wire fetch_pkg::br_exec_t upd
);
   import fetch_pkg::*;
   logic [1:0] ctr_mem [BHT_ENTRIES];
   wire [BHT_IDX_W-1:0] rd_idx = rd_pc[INSN_LSB +: BHT_IDX_W];
   wire [BHT_IDX_W-1:0] up_idx = upd.pc[INSN_LSB +: BHT_IDX_W];
   wire [1:0] cur = ctr_mem[up_idx];
   wire do_upd = upd.valid && upd.cond_bit;
   wire [1:0] inc = (cur == BHT_MAX) ? cur : cur + 2'h1;
   wire [1:0] dec = (cur == BHT_MIN) ? cur : cur - 2'h1;
   wire [1:0] nxt = upd.taken ? inc : dec;

   assign rd_taken = ctr_mem[rd_idx][1];

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         for (int i = 0; i < BHT_ENTRIES; i++) ctr_mem[i] <= BHT_RESET;
      end else if (do_upd) begin
         ctr_mem[up_idx] <= nxt;
      end
   end

   property p_bht_step;
      @(posedge clk) disable iff (!rst_n)
      (do_upd && upd.taken && cur != BHT_MAX) |=> ctr_mem[$past(up_idx)] == $past(cur) + 2'h1;
   endproperty
   a_bht_step: assert property (p_bht_step) else $error("History counter did not step toward taken.");

   property p_bht_floor;
      @(posedge clk) disable iff (!rst_n)
      (do_upd && !upd.taken && cur == BHT_MIN) |=> ctr_mem[$past(up_idx)] == BHT_MIN;
   endproperty
   a_bht_floor: assert property (p_bht_floor) else $error("History counter wrapped below its floor.");
endmodule : branch_history_table
`default_nettype wire

// ==== fetch_branch_predict_unit.sv ====
// Purpose: Fetch front end with line fill, branch prediction and write-back ordering.
// Assumes: One clock; the cache tags and the bus are outside this block.
// Notes: All outputs are registered, so every answer lands one edge after its cause.
`timescale 1ns/10ps
`default_nettype none
module fetch_branch_predict_unit (
   input wire logic MCLK,
   input wire logic RST_N,
   input wire logic FETCH_VALID,
   input wire logic [fetch_pkg::ADDR_W-1:0] FETCH_ADDR,
   input wire logic [fetch_pkg::CNT_W-1:0] FETCH_COUNT,
   input wire logic ICACHE_HIT,
   input wire logic [fetch_pkg::DW_W-1:0] ICACHE_DATA,
   output logic BUS_REQ,
   input wire logic ADDR_GRANT,
   output logic ADDR_VALID,
   output logic [fetch_pkg::ADDR_W-1:0] BUS_ADDR,
   input wire logic DATA_GRANT,
   input wire logic BEAT_VALID,
   input wire logic [fetch_pkg::DW_W-1:0] BEAT_DATA,
   output logic FILL_BUSY,
   output logic FILL_WR,
   output logic [fetch_pkg::ADDR_W-1:0] FILL_ADDR,
   output logic [fetch_pkg::DW_W-1:0] FILL_DATA,
   output logic IQ_LOAD,
   output logic [fetch_pkg::INSN_W-1:0] IQ_INSN0,
   output logic [fetch_pkg::INSN_W-1:0] IQ_INSN1,
   output logic [fetch_pkg::ADDR_W-1:0] NEXT_FETCH_ADDR,
   output logic BTC_HIT,
   input wire fetch_pkg::br_dec_t DEC_BRANCH,
   input wire logic [fetch_pkg::ADDR_W-1:0] LOOP_COUNT,
   output logic REDIRECT_VALID,
   output logic [fetch_pkg::ADDR_W-1:0] REDIRECT_ADDR,
   output logic PREDICT_TAKEN,
   input wire fetch_pkg::br_exec_t EXEC_BRANCH,
   input wire fetch_pkg::cmp_slot_t [fetch_pkg::CMP_SLOTS-1:0] CMP_SLOT,
   output logic [fetch_pkg::CMP_SLOTS-1:0] WB_GRANT
);
   import fetch_pkg::*;

   typedef enum logic [1:0] {FILL_IDLE, FILL_ARB, FILL_SEND, FILL_BEATS} fill_state_t;

   fill_state_t state_reg, state_next;
   logic [ADDR_W-1:0] fill_addr_reg, fill_addr_next;
   logic [ADDR_W-1:0] pend_addr_reg, pend_addr_next;
   logic pend_reg, pend_next;
   logic [BEAT_W-1:0] beat_reg, beat_next;
   logic bus_req_reg, bus_req_next;
   logic addr_valid_reg, addr_valid_next;
   logic fill_wr_reg, fill_busy_reg;
   logic [ADDR_W-1:0] fill_waddr_reg;
   logic [DW_W-1:0] fill_data_reg;
   logic iq_load_reg, iq_load_next;
   logic [DW_W-1:0] iq_dw_reg, iq_dw_next;
   logic [ADDR_W-1:0] next_fetch_reg, next_fetch_next;
   logic btc_hit_reg;
   logic redirect_reg;
   logic [ADDR_W-1:0] redirect_addr_reg;
   logic pred_taken_reg;
   logic [CMP_SLOTS-1:0] wb_grant_reg;

   // Fill control decode.
   wire miss = FETCH_VALID && !ICACHE_HIT;
   wire busy = state_reg != FILL_IDLE;
   wire same_line = FETCH_ADDR[ADDR_W-1:LINE_LSB] == fill_addr_reg[ADDR_W-1:LINE_LSB];
   wire take_beat = state_reg == FILL_BEATS && BEAT_VALID;
   wire last_beat = take_beat && beat_reg == LAST_BEAT;
   wire [ADDR_W-1:0] start_addr = pend_reg ? pend_addr_reg : FETCH_ADDR;
   wire start = !busy && (pend_reg || miss);
   wire park = miss && busy && !same_line && !pend_reg;
   wire [BEAT_W-1:0] beat_word = fill_addr_reg[DW_LSB +: BEAT_W] + beat_reg;
   wire [ADDR_W-1:0] beat_addr = {fill_addr_reg[ADDR_W-1:LINE_LSB], beat_word, 3'h0};

   always_comb begin
      state_next = state_reg;
      fill_addr_next = fill_addr_reg;
      beat_next = beat_reg;
      bus_req_next = 1'b0;
      addr_valid_next = 1'b0;
      unique case (state_reg)
         FILL_IDLE: begin
            if (start) begin
               state_next = FILL_ARB;
               fill_addr_next = start_addr;
               bus_req_next = 1'b1;
            end
         end
         FILL_ARB: begin
            bus_req_next = !ADDR_GRANT;
            if (ADDR_GRANT) begin
               state_next = FILL_SEND;
               addr_valid_next = 1'b1;
            end
         end
         FILL_SEND: begin
            if (DATA_GRANT) begin
               state_next = FILL_BEATS;
               beat_next = '0;
            end
         end
         FILL_BEATS: begin
            if (take_beat) beat_next = beat_reg + 1'b1;
            if (last_beat) state_next = FILL_IDLE;
         end
      endcase
   end

   // A parked miss is held until the running fill has written its last beat.
   assign pend_next = park ? 1'b1 : (start && pend_reg) ? 1'b0 : pend_reg;
   assign pend_addr_next = park ? FETCH_ADDR : pend_addr_reg;

   // Beats win the queue port; a hit in the same cycle is replayed by the fetcher.
   assign iq_load_next = take_beat || (FETCH_VALID && ICACHE_HIT);
   assign iq_dw_next = take_beat ? BEAT_DATA : ICACHE_DATA;

   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         state_reg <= FILL_IDLE;
         fill_addr_reg <= '0;
         pend_reg <= 1'b0;
         pend_addr_reg <= '0;
         beat_reg <= '0;
         bus_req_reg <= 1'b0;
         addr_valid_reg <= 1'b0;
         fill_busy_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         fill_addr_reg <= fill_addr_next;
         pend_reg <= pend_next;
         pend_addr_reg <= pend_addr_next;
         beat_reg <= beat_next;
         bus_req_reg <= bus_req_next;
         addr_valid_reg <= addr_valid_next;
         fill_busy_reg <= state_next != FILL_IDLE;
      end
   end

   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         fill_wr_reg <= 1'b0;
         fill_waddr_reg <= '0;
         fill_data_reg <= '0;
         iq_load_reg <= 1'b0;
         iq_dw_reg <= '0;
      end else begin
         fill_wr_reg <= take_beat;
         fill_waddr_reg <= beat_addr;
         fill_data_reg <= BEAT_DATA;
         iq_load_reg <= iq_load_next;
         iq_dw_reg <= iq_dw_next;
      end
   end

   // Branch prediction.
   logic btc_hit;
   logic [ADDR_W-1:0] btc_target;
   logic bht_taken;

   branch_target_cache u_btc (
      .clk(MCLK),
      .rst_n(RST_N),
      .look_addr(FETCH_ADDR),
      .look_hit(btc_hit),
      .look_target(btc_target),
      .upd(EXEC_BRANCH)
   );

   branch_history_table u_bht (
      .clk(MCLK),
      .rst_n(RST_N),
      .rd_pc(DEC_BRANCH.pc),
      .rd_taken(bht_taken),
      .upd(EXEC_BRANCH)
   );

   wire loop_exits = LOOP_COUNT == ONE_LOOP;
   wire loop_taken = loop_exits == DEC_BRANCH.exit_on_last;
   wire dec_taken = DEC_BRANCH.kind == BR_UNCOND ? 1'b1 :
                    DEC_BRANCH.kind == BR_LOOP ? loop_taken :
                    DEC_BRANCH.kind == BR_COND_BIT ? bht_taken : DEC_BRANCH.early_taken;
   wire redirect = DEC_BRANCH.valid && dec_taken != DEC_BRANCH.early_taken;
   wire [ADDR_W-1:0] redirect_to = dec_taken ? DEC_BRANCH.target : DEC_BRANCH.fall_thru;
   wire [ADDR_W-1:0] seq_addr = FETCH_ADDR + {{(ADDR_W-CNT_W-INSN_LSB){1'b0}}, FETCH_COUNT, 2'h0};

   // A decode correction outranks the fetch-stage guess made the same cycle.
   assign next_fetch_next = redirect ? redirect_to :
                            !FETCH_VALID ? next_fetch_reg :
                            btc_hit ? btc_target : seq_addr;

   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         next_fetch_reg <= '0;
         btc_hit_reg <= 1'b0;
         redirect_reg <= 1'b0;
         redirect_addr_reg <= '0;
         pred_taken_reg <= 1'b0;
      end else begin
         next_fetch_reg <= next_fetch_next;
         btc_hit_reg <= FETCH_VALID && btc_hit;
         redirect_reg <= redirect;
         redirect_addr_reg <= redirect_to;
         pred_taken_reg <= DEC_BRANCH.valid && dec_taken;
      end
   end

   // Completion and write-back, slot 0 oldest.
   logic [CMP_SLOTS-1:0] grant_w;
   logic [CMP_SLOTS:0] order_ok;
   logic [CMP_SLOTS:0] branch_seen;
   logic [1:0] gpr_used [CMP_SLOTS+1];
   assign order_ok[0] = 1'b1;
   assign branch_seen[0] = 1'b0;
   assign gpr_used[0] = 2'h0;

   genvar g;
   for (g = 0; g < CMP_SLOTS; g++) begin : g_wb
      wire done = CMP_SLOT[g].finished || CMP_SLOT[g].final_exec;
      wire port_ok = !CMP_SLOT[g].uses_gpr || gpr_used[g] < 2'(GPR_PORTS);
      assign grant_w[g] = CMP_SLOT[g].valid && done && order_ok[g] && port_ok && !branch_seen[g];
      assign order_ok[g+1] = order_ok[g] && grant_w[g];
      assign branch_seen[g+1] = branch_seen[g] || (grant_w[g] && CMP_SLOT[g].taken_branch);
      assign gpr_used[g+1] = gpr_used[g] + {1'b0, grant_w[g] && CMP_SLOT[g].uses_gpr};
   end

   always_ff @(posedge MCLK) begin
      if (!RST_N) wb_grant_reg <= '0;
      else wb_grant_reg <= grant_w;
   end

   assign BUS_REQ = bus_req_reg;
   assign ADDR_VALID = addr_valid_reg;
   assign BUS_ADDR = {fill_addr_reg[ADDR_W-1:DW_LSB], 3'h0};
   assign FILL_BUSY = fill_busy_reg;
   assign FILL_WR = fill_wr_reg;
   assign FILL_ADDR = fill_waddr_reg;
   assign FILL_DATA = fill_data_reg;
   assign IQ_LOAD = iq_load_reg;
   assign IQ_INSN0 = iq_dw_reg[DW_W-1:INSN_W];
   assign IQ_INSN1 = iq_dw_reg[INSN_W-1:0];
   assign NEXT_FETCH_ADDR = next_fetch_reg;
   assign BTC_HIT = btc_hit_reg;
   assign REDIRECT_VALID = redirect_reg;
   assign REDIRECT_ADDR = redirect_addr_reg;
   assign PREDICT_TAKEN = pred_taken_reg;
   assign WB_GRANT = wb_grant_reg;

   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RST_N);

   property p_miss_starts;
      (!busy && !pend_reg && miss) |=> BUS_REQ && FILL_BUSY;
   endproperty
   a_miss_starts: assert property (p_miss_starts) else $error("Miss did not start a fill.");

   property p_addr_after_arb;
      ADDR_VALID |-> $past(state_reg == FILL_ARB && ADDR_GRANT);
   endproperty
   a_addr_after_arb: assert property (p_addr_after_arb) else $error("Address driven without arbitration.");

   property p_crit_first;
      (take_beat && beat_reg == '0) |=> FILL_WR && FILL_ADDR[DW_LSB +: BEAT_W] == fill_addr_reg[DW_LSB +: BEAT_W];
   endproperty
   a_crit_first: assert property (p_crit_first) else $error("First beat was not the critical word.");

   property p_beat_forward;
      take_beat |=> FILL_WR && IQ_LOAD && IQ_INSN1 == $past(BEAT_DATA[INSN_W-1:0]);
   endproperty
   a_beat_forward: assert property (p_beat_forward) else $error("Beat was not forwarded at once.");

   property p_hit_in_fill;
      (busy && FETCH_VALID && ICACHE_HIT && !take_beat) |=> IQ_LOAD && IQ_INSN0 == $past(ICACHE_DATA[DW_W-1:INSN_W]);
   endproperty
   a_hit_in_fill: assert property (p_hit_in_fill) else $error("Hit during fill was not served.");

   property p_second_held;
      (pend_reg && busy) |=> pend_reg && $stable(pend_addr_reg) && $stable(fill_addr_reg);
   endproperty
   a_second_held: assert property (p_second_held) else $error("Second fill started too early.");

   property p_four_beats;
      (state_reg == FILL_BEATS && beat_reg == LAST_BEAT && BEAT_VALID) |=> state_reg == FILL_IDLE;
   endproperty
   a_four_beats: assert property (p_four_beats) else $error("Fill did not end after four beats.");

   property p_btc_next;
      (FETCH_VALID && btc_hit && !redirect) |=> BTC_HIT && NEXT_FETCH_ADDR == $past(btc_target);
   endproperty
   a_btc_next: assert property (p_btc_next) else $error("Target hit not fetched next cycle.");
   property p_seq_next;
      (FETCH_VALID && !btc_hit && !redirect) |=> NEXT_FETCH_ADDR == $past(seq_addr);
   endproperty
   a_seq_next: assert property (p_seq_next) else $error("Sequential address wrong.");

   property p_uncond_fix;
      (DEC_BRANCH.valid && DEC_BRANCH.kind == BR_UNCOND && !DEC_BRANCH.early_taken)
         |=> REDIRECT_VALID && REDIRECT_ADDR == $past(DEC_BRANCH.target);
   endproperty
   a_uncond_fix: assert property (p_uncond_fix) else $error("Unconditional branch not redirected.");
   property p_two_ports;
      gpr_used[CMP_SLOTS] <= 2'(GPR_PORTS);
   endproperty
   a_two_ports: assert property (p_two_ports) else $error("More than two register write-backs.");
   property p_in_order;
      grant_w[1] |-> grant_w[0];
   endproperty
   a_in_order: assert property (p_in_order) else $error("Younger slot wrote back before older.");
   property p_branch_delay;
      (grant_w[0] && CMP_SLOT[0].taken_branch) |-> !grant_w[1];
   endproperty
   a_branch_delay: assert property (p_branch_delay) else $error("Target-path slot was not delayed.");
   c_full_fill: cover property (take_beat && beat_reg == LAST_BEAT);
   c_btc_hit: cover property (FETCH_VALID && btc_hit);
   c_redirect: cover property (redirect);
   c_two_ports: cover property (gpr_used[CMP_SLOTS] == 2'h2);
endmodule : fetch_branch_predict_unit
`default_nettype wire

// ==== fill_bus_model.sv ====
// Purpose: Bus and memory model that answers line-fill requests.
// Assumes: Beat data is the double word address, then that address plus four.
// Notes: A nonzero delay stalls each grant and each beat after the first by that many cycles.
`timescale 1ns/10ps
`default_nettype none
module fill_bus_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [2:0] dly,
   input wire logic bus_req,
   output logic addr_grant,
   input wire logic addr_valid,
   input wire logic [31:0] bus_addr,
   output logic data_grant,
   output logic beat_valid,
   output logic [63:0] beat_data
);
   logic [31:0] a_reg;
   logic [1:0] ph_reg;
   logic [1:0] k_reg;
   logic [2:0] w_reg;
   logic [31:0] dwa;
   // Beats wrap from the critical double word, so a wrong order shows in the data.
   assign dwa = {a_reg[31:5], a_reg[4:3] + k_reg, 3'h0};
   always_ff @(posedge clk) begin
      addr_grant <= 1'h0;
      data_grant <= 1'h0;
      beat_valid <= 1'h0;
      // A released data bus must not keep showing the last beat.
      beat_data <= ~beat_data;
      if (!rst_n) begin
         ph_reg <= 2'h0;
         w_reg <= 3'h0;
         beat_data <= 64'h0;
      end else if (addr_valid) begin
         a_reg <= bus_addr;
         ph_reg <= 2'h1;
         w_reg <= 3'h0;
      end else if (ph_reg == 2'h0) begin
         if (bus_req && !addr_grant) begin
            w_reg <= w_reg + 3'h1;
            if (w_reg >= dly) begin
               addr_grant <= 1'h1;
               w_reg <= 3'h0;
            end
         end
      end else if (w_reg < dly) begin
         w_reg <= w_reg + 3'h1;
      end else if (ph_reg == 2'h1) begin
         data_grant <= 1'h1;
         ph_reg <= 2'h2;
         k_reg <= 2'h0;
      end else begin
         beat_valid <= 1'h1;
         beat_data <= {dwa, dwa + 32'h4};
         k_reg <= k_reg + 2'h1;
         w_reg <= 3'h0;
         if (k_reg == 2'h3) begin
            ph_reg <= 2'h0;
         end
      end
   end
endmodule : fill_bus_model
`default_nettype wire

// ==== testbench.sv ====
// Purpose: Self-checking bench for the fetch and branch prediction unit.
// Assumes: Inputs change at the falling edge; outputs are read one edge later.
// Notes: Every wait is bounded and a timeout ends the run as a failure.
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import fetch_pkg::*;
   logic MCLK, RST_N, FETCH_VALID, ICACHE_HIT, BUS_REQ, ADDR_GRANT, ADDR_VALID, DATA_GRANT, BEAT_VALID;
   logic FILL_BUSY, FILL_WR, IQ_LOAD, BTC_HIT, REDIRECT_VALID, PREDICT_TAKEN;
   logic [2:0] FETCH_COUNT, dly;
   logic [31:0] FETCH_ADDR, BUS_ADDR, FILL_ADDR, IQ_INSN0, IQ_INSN1, NEXT_FETCH_ADDR, LOOP_COUNT, REDIRECT_ADDR;
   logic [63:0] ICACHE_DATA, BEAT_DATA, FILL_DATA;
   logic [3:0] WB_GRANT;
   br_dec_t DEC_BRANCH;
   br_exec_t EXEC_BRANCH;
   cmp_slot_t [3:0] CMP_SLOT;
   int err_count = 0;
   int compares = 0;
   localparam cmp_slot_t FIN = '{1'h1, 1'h1, 1'h0, 1'h1, 1'h0};
   localparam cmp_slot_t PEND = '{1'h1, 1'h0, 1'h0, 1'h1, 1'h0};
   localparam cmp_slot_t BRT = '{1'h1, 1'h1, 1'h0, 1'h0, 1'h1};
   localparam cmp_slot_t FX = '{1'h1, 1'h0, 1'h1, 1'h1, 1'h0};
   localparam cmp_slot_t NO = '0;
   fetch_branch_predict_unit uut (.*);
   fill_bus_model partner (.clk(MCLK), .rst_n(RST_N), .dly(dly), .bus_req(BUS_REQ), .addr_grant(ADDR_GRANT),
      .addr_valid(ADDR_VALID), .bus_addr(BUS_ADDR), .data_grant(DATA_GRANT), .beat_valid(BEAT_VALID),
      .beat_data(BEAT_DATA));
   initial begin
      MCLK = 1'h0;
      forever #5 MCLK = ~MCLK;
   end
   task chk(input string n, input logic [31:0] e, input logic [31:0] s);
      compares++;
      if (s !== e) begin
         $display("ERROR %s expected %h seen %h", n, e, s);
         err_count++;
      end
   endtask : chk
   task end_sim;
      $display("mismatches %0d compares %0d", err_count, compares);
      if (err_count == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : end_sim
   // Waits for ADDR_VALID (0) or FILL_WR (1), giving up after 50 cycles.
   task wt(input int w);
      int i;
      for (i = 0; i < 50; i++) begin
         if ((w == 0 && ADDR_VALID === 1'h1) || (w == 1 && FILL_WR === 1'h1)) break;
         @(negedge MCLK);
      end
      if (i == 50) begin
         $display("ERROR wait %0d expected 1 seen 0", w);
         err_count++;
         end_sim();
      end
   endtask : wt
   task fetch(input logic [31:0] a, input logic hit, input logic [2:0] n);
      FETCH_VALID = 1'h1;
      FETCH_ADDR = a;
      ICACHE_HIT = hit;
      FETCH_COUNT = n;
      @(negedge MCLK);
      FETCH_VALID = 1'h0;
      ICACHE_HIT = 1'h1;
   endtask : fetch
   task beats(input logic [31:0] a);
      logic [31:0] e;
      int k;
      wt(0);
      chk("BUS_ADDR", a & ~32'h7, BUS_ADDR);
      for (k = 0; k < 4; k++) begin
         wt(1);
         e = {a[31:5], 2'(a[4:3] + 2'(k)), 3'h0};
         chk("FILL_ADDR", e, FILL_ADDR);
         chk("IQ_INSN0", e, IQ_INSN0);
         chk("IQ_INSN1", e + 32'h4, IQ_INSN1);
         chk("FILL_DATA", e, FILL_DATA[63:32]);
         chk("FILL_BUSY", 32'(k != 3), 32'(FILL_BUSY));
         chk("BUS_REQ", 32'h0, 32'(BUS_REQ));
         @(negedge MCLK);
         if (dly != 3'h0) chk("IQ_LOAD", 32'h0, 32'(IQ_LOAD));
      end
   endtask : beats
   task ex(input logic c, input logic t, input logic [31:0] fa, input logic [31:0] pc, input logic [31:0] tg);
      EXEC_BRANCH = '{1'h1, c, t, fa, pc, tg};
      @(negedge MCLK);
      EXEC_BRANCH = '0;
      @(negedge MCLK);
   endtask : ex
   task dec(input br_kind_t k, input logic early, input logic exl, input logic [31:0] lc, input logic et);
      DEC_BRANCH = '{1'h1, k, 32'h200, 32'h900, 32'h204, early, exl};
      LOOP_COUNT = lc;
      @(negedge MCLK);
      DEC_BRANCH = '0;
      chk("PREDICT_TAKEN", 32'(et), 32'(PREDICT_TAKEN));
      chk("REDIRECT_VALID", 32'(et != early), 32'(REDIRECT_VALID));
      if (et != early) chk("REDIRECT_ADDR", et ? 32'h900 : 32'h204, REDIRECT_ADDR);
   endtask : dec
   task wb(input cmp_slot_t [3:0] s, input logic [3:0] e);
      CMP_SLOT = s;
      @(negedge MCLK);
      CMP_SLOT = '0;
      chk("WB_GRANT", 32'(e), 32'(WB_GRANT));
   endtask : wb
   task t_fill;
      dly = 3'h0;
      fetch(32'h1010, 1'h0, 3'h0);
      chk("BUS_REQ", 32'h1, 32'(BUS_REQ));
      beats(32'h1010);
   endtask : t_fill
   // A slow partner leaves room for a hit and a second miss while the first fill runs.
   task t_park;
      dly = 3'h2;
      fetch(32'h2018, 1'h0, 3'h0);
      fetch(32'h3000, 1'h1, 3'h2);
      chk("IQ_LOAD", 32'h1, 32'(IQ_LOAD));
      chk("IQ_INSN0", 32'h1111_2222, IQ_INSN0);
      fetch(32'h4008, 1'h0, 3'h0);
      beats(32'h2018);
      beats(32'h4008);
   endtask : t_park
   task t_btc;
      ex(1'h0, 1'h1, 32'h100, 32'h108, 32'h800);
      fetch(32'h100, 1'h1, 3'h4);
      chk("BTC_HIT", 32'h1, 32'(BTC_HIT));
      chk("NEXT_FETCH_ADDR", 32'h800, NEXT_FETCH_ADDR);
      fetch(32'h104, 1'h1, 3'h3);
      chk("NEXT_FETCH_ADDR", 32'h110, NEXT_FETCH_ADDR);
      chk("BTC_HIT", 32'h0, 32'(BTC_HIT));
   endtask : t_btc
   task t_pred;
      dec(BR_UNCOND, 1'h0, 1'h0, 32'h5, 1'h1);
      dec(BR_UNCOND, 1'h1, 1'h0, 32'h5, 1'h1);
      dec(BR_LOOP, 1'h0, 1'h1, 32'h1, 1'h1);
      dec(BR_LOOP, 1'h1, 1'h1, 32'h5, 1'h0);
      dec(BR_LOOP, 1'h1, 1'h0, 32'h5, 1'h1);
      dec(BR_OTHER, 1'h1, 1'h0, 32'h5, 1'h1);
      dec(BR_COND_BIT, 1'h1, 1'h0, 32'h5, 1'h0);
      ex(1'h1, 1'h1, 32'h300, 32'h200, 32'h900);
      ex(1'h1, 1'h1, 32'h300, 32'h200, 32'h900);
      dec(BR_COND_BIT, 1'h0, 1'h0, 32'h5, 1'h1);
      ex(1'h1, 1'h0, 32'h300, 32'h200, 32'h900);
      dec(BR_COND_BIT, 1'h1, 1'h0, 32'h5, 1'h1);
      repeat (3) ex(1'h1, 1'h0, 32'h300, 32'h200, 32'h900);
      ex(1'h1, 1'h1, 32'h300, 32'h200, 32'h900);
      dec(BR_COND_BIT, 1'h0, 1'h0, 32'h5, 1'h0);
   endtask : t_pred
   task t_wb;
      wb('{NO, NO, FIN, PEND}, 4'h0);
      wb('{FIN, FIN, FIN, FIN}, 4'h3);
      wb('{NO, NO, FIN, BRT}, 4'h1);
      wb('{NO, NO, FX, FIN}, 4'h3);
   endtask : t_wb
   initial begin
      RST_N = 1'h0;
      FETCH_VALID = 1'h0;
      FETCH_ADDR = 32'h0;
      FETCH_COUNT = 3'h0;
      ICACHE_HIT = 1'h1;
      ICACHE_DATA = 64'h1111_2222_3333_4444;
      DEC_BRANCH = '0;
      LOOP_COUNT = 32'h0;
      EXEC_BRANCH = '0;
      CMP_SLOT = '0;
      dly = 3'h0;
      repeat (5) @(negedge MCLK);
      RST_N = 1'h1;
      @(negedge MCLK);
      t_fill();
      t_park();
      t_btc();
      t_pred();
      t_wb();
      end_sim();
   end
endmodule : testbench
`default_nettype wire
